// ---- logic/align_ctrl_consts.svh ----
`ifndef ALIGN_CTRL_CONSTS_SVH
`define ALIGN_CTRL_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_IFACE_CFG 15'h0000
`define OFS_DEV_MODE 15'h0002
`define OFS_MAKER_ID_LO 15'h000c
`define OFS_MAKER_ID_HI 15'h000d
`define OFS_USER_IF 15'h0010
`define OFS_CLK_CTRL 15'h0029
`define OFS_POS_B0 15'h002c
`define OFS_POS_B1 15'h002d
`define OFS_POS_B2 15'h002e

// ==========================================================
// reset values
`define RST_IFACE_CFG 8'h30
`define RST_DEV_MODE 8'h00
`define RST_USER_IF 8'h00
`define RST_CLK_CTRL 8'h80

// ==========================================================
// field positions
`define BIT_SOFT_RESET 7
`define BIT_ASCEND 5
`define BIT_SEP_OUT 4
`define BIT_ADDR_HOLD 0
`define BIT_PROC_EN 6
`define BIT_RECV_EN 5
`define BIT_FINE_SCALE 4
`define MODE_POWER_DOWN 2'h3

// ==========================================================
// timing
`define CLK_PERIOD_NS 50
`define SOFT_RESET_NS 750
`define SOFT_RESET_CYC ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC 2

`endif

// ---- logic/align_ctrl_pkg.sv ----
package align_ctrl_pkg;
  typedef logic [14:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    op_normal,
    op_rsvd1,
    op_rsvd2,
    op_power_down
  } op_mode_t;
endpackage : align_ctrl_pkg

// ---- logic/serial_port_if.sv ----
`timescale 1ns/100ps
interface serial_port_if;
  logic sclk;
  logic sel_n;
  logic sdi;
  logic serial_out_line;
  modport device (input sclk, input sel_n, input sdi, output serial_out_line);
  modport host (output sclk, output sel_n, output sdi, input serial_out_line);
endinterface : serial_port_if

// ---- logic/spi_config_and_align_ctrl.sv ----
`timescale 1ns/100ps
`include "align_ctrl_consts.svh"

// Function
// RL1: bit 7 soft-resets all registers, self-clears
// RL2: host idle 750ns after soft reset
// RL3: streaming address decrements if bit 5 zero
// RL4: bit 4 reads one; reads on output line
// RL5: host writes reserved fields with defaults
// RL6: mode 0 normal, 3 power down
// RL7: maker code read-only 16-bit constant
// RL8: address hold keeps streaming address constant
// RL9: host enables receiver before processor
// RL10: align events processed only with enable
// RL11: zoom bit shrinks window delay steps
// RL12: four-bit field selects capture delay
// RL13: edge position is read-only 24-bit status
module spi_config_and_align_ctrl #(
  parameter logic [15:0] MAKER_CODE = 16'h5a5a  // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial port
  serial_port_if.device sp,
  // alignment path
  input wire logic align_event,
  input wire logic [23:0] align_edge_position,
  output logic align_input_receiver_enable,
  output logic align_event_process_enable,
  output logic fine_window_scale,
  output logic [3:0] align_delay_choice,
  output logic align_event_taken,
  output logic power_down,
  output logic soft_reset_busy
);
  import align_ctrl_pkg::*;

  // ==========================================================
  // registers
  reg_byte_t iface_cfg;
  reg_byte_t dev_mode;
  reg_byte_t user_if;
  reg_byte_t clk_ctrl;
  logic [4:0] rst_cnt;
  logic soft_rst;

  // ==========================================================
  // serial front end
  logic sclk_q, sel_n_q, sdi_q;
  logic sclk_rise, sclk_fall;
  logic [5:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic rd_cmd;
  reg_addr_t addr;
  logic in_data;
  logic out_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
      sdi_q <= 1'b0;
    end else begin
      sclk_q <= sp.sclk;
      sel_n_q <= sp.sel_n;
      sdi_q <= sp.sdi;
    end
  end

  assign sclk_rise = !sel_n_q && sp.sclk && !sclk_q;
  assign sclk_fall = !sel_n_q && !sp.sclk && sclk_q;

  function automatic reg_byte_t read_reg(input reg_addr_t a);
    unique case (a)
      `OFS_IFACE_CFG: read_reg = iface_cfg | (8'h01 << `BIT_SEP_OUT);  // RL4
      `OFS_DEV_MODE: read_reg = dev_mode;
      `OFS_MAKER_ID_LO: read_reg = MAKER_CODE[7:0];  // RL7
      `OFS_MAKER_ID_HI: read_reg = MAKER_CODE[15:8];  // RL7
      `OFS_USER_IF: read_reg = user_if;
      `OFS_CLK_CTRL: read_reg = clk_ctrl;
      `OFS_POS_B0: read_reg = align_edge_position[7:0];  // RL13
      `OFS_POS_B1: read_reg = align_edge_position[15:8];  // RL13
      `OFS_POS_B2: read_reg = align_edge_position[23:16];  // RL13
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  function automatic reg_addr_t step_addr(input reg_addr_t a);
    if (user_if[`BIT_ADDR_HOLD]) begin
      step_addr = a;  // RL8
    end else if (iface_cfg[`BIT_ASCEND]) begin
      step_addr = a + 15'h0001;  // RL3
    end else begin
      step_addr = a - 15'h0001;  // RL3
    end
  endfunction : step_addr

  logic [7:0] next_byte;
  logic byte_done;
  assign next_byte = {shift_in[6:0], sdi_q};
  assign byte_done = sclk_rise && in_data && (bit_cnt[2:0] == 3'h7);

  // frame: 1 r/w bit, 15 address bits, then data bytes
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst || sel_n_q) begin
      bit_cnt <= 6'h00;
      shift_in <= 8'h00;
      rd_cmd <= 1'b0;
      addr <= 15'h0000;
      in_data <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= next_byte;
      if (!in_data) begin
        if (bit_cnt == 6'h00) begin
          rd_cmd <= sdi_q;
        end else begin
          addr <= {addr[13:0], sdi_q};
        end
        if (bit_cnt == 6'h0f) begin
          in_data <= 1'b1;
          bit_cnt <= 6'h00;
        end else begin
          bit_cnt <= bit_cnt + 6'h01;
        end
      end else begin
        bit_cnt <= {3'h0, bit_cnt[2:0] + 3'h1};
        if (bit_cnt[2:0] == 3'h7) begin
          addr <= step_addr(addr);
        end
      end
    end
  end

  // byte to launch; always_comb so register contents count as inputs
  logic [7:0] load_byte;
  always_comb begin
    load_byte = read_reg(addr);
  end

  // read data shifts out msb first on the falling edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sel_n_q) begin
      shift_out <= 8'h00;
      out_q <= 1'b0;
    end else if (sclk_fall && in_data) begin
      if (bit_cnt[2:0] == 3'h0) begin
        shift_out <= {load_byte[6:0], 1'b0};
        out_q <= load_byte[7] & rd_cmd;  // RL4
      end else begin
        shift_out <= {shift_out[6:0], 1'b0};
        out_q <= shift_out[7] & rd_cmd;  // RL4
      end
    end
  end
  assign sp.serial_out_line = out_q;

  // ==========================================================
  // register writes
  logic wr_stb;
  assign wr_stb = byte_done && !rd_cmd;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      iface_cfg <= `RST_IFACE_CFG;  // RL1
      dev_mode <= `RST_DEV_MODE;
      user_if <= `RST_USER_IF;
      clk_ctrl <= `RST_CLK_CTRL;
    end else if (wr_stb) begin
      unique case (addr)
        `OFS_IFACE_CFG: iface_cfg <= next_byte | (8'h01 << `BIT_SEP_OUT);
        `OFS_DEV_MODE: dev_mode <= next_byte;
        `OFS_USER_IF: user_if <= next_byte;
        `OFS_CLK_CTRL: clk_ctrl <= next_byte;
        default: ;
      endcase
    end
  end

  // soft reset: held for the full settle time, then bit self-clears
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rst_cnt <= 5'h00;
      soft_rst <= 1'b0;
    end else if (soft_rst) begin
      if (rst_cnt == 5'(`SOFT_RESET_CYC - 1)) begin
        soft_rst <= 1'b0;  // RL1
        rst_cnt <= 5'h00;
      end else begin
        rst_cnt <= rst_cnt + 5'h01;
      end
    end else if (wr_stb && addr == `OFS_IFACE_CFG && next_byte[`BIT_SOFT_RESET]) begin
      soft_rst <= 1'b1;  // RL1
    end
  end

  // ==========================================================
  // alignment outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      align_input_receiver_enable <= 1'b0;
      align_event_process_enable <= 1'b0;
      fine_window_scale <= 1'b0;
      align_delay_choice <= 4'h0;
      align_event_taken <= 1'b0;
      power_down <= 1'b0;
      soft_reset_busy <= 1'b0;
    end else begin
      align_input_receiver_enable <= clk_ctrl[`BIT_RECV_EN];
      align_event_process_enable <= clk_ctrl[`BIT_PROC_EN];
      fine_window_scale <= clk_ctrl[`BIT_FINE_SCALE];  // RL11
      align_delay_choice <= clk_ctrl[3:0];  // RL12
      align_event_taken <= align_event && clk_ctrl[`BIT_PROC_EN]  // RL10
        && clk_ctrl[`BIT_RECV_EN] && !soft_rst;
      power_down <= (op_mode_t'(dev_mode[1:0]) == op_power_down);  // RL6
      soft_reset_busy <= soft_rst;
    end
  end
endmodule : spi_config_and_align_ctrl

// ---- logic/spi_config_host.sv ----
`timescale 1ns/100ps
`include "align_ctrl_consts.svh"

module spi_config_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // user command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire align_ctrl_pkg::reg_addr_t cmd_addr,
  input wire align_ctrl_pkg::reg_byte_t cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output align_ctrl_pkg::reg_byte_t rsp_rdata,
  // serial port
  serial_port_if.host sp
);
  import align_ctrl_pkg::*;

  typedef enum logic [1:0] {st_idle, st_shift, st_guard} host_state_t;
  host_state_t state;
  logic [23:0] frame;
  logic [4:0] bits_left;
  logic [1:0] half_cnt;
  logic [5:0] guard_cnt;
  logic sclk_r, sel_n_r, sdi_r, rd_r, soft_req;
  reg_byte_t rx;

  assign sp.sclk = sclk_r;
  assign sp.sel_n = sel_n_r;
  assign sp.sdi = sdi_r;

  // ==========================================================
  // single-byte frame engine
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= st_idle;
      frame <= 24'h000000;
      bits_left <= 5'h00;
      half_cnt <= 2'h0;
      guard_cnt <= 6'h00;
      sclk_r <= 1'b0;
      sel_n_r <= 1'b1;
      sdi_r <= 1'b0;
      rd_r <= 1'b0;
      soft_req <= 1'b0;
      rx <= 8'h00;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state)
        st_idle: begin
          cmd_ready <= !cmd_ready;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            frame <= {cmd_read, cmd_addr, cmd_wdata};  // RL5
            rd_r <= cmd_read;
            soft_req <= !cmd_read && cmd_addr == `OFS_IFACE_CFG
              && cmd_wdata[`BIT_SOFT_RESET];
            sel_n_r <= 1'b0;
            sdi_r <= cmd_read;
            bits_left <= 5'h18;
            half_cnt <= 2'h0;
            state <= st_shift;
          end
        end
        st_shift: begin
          if (half_cnt == 2'(`SCLK_HALF_CYC - 1)) begin
            half_cnt <= 2'h0;
            sclk_r <= !sclk_r;
            if (!sclk_r) begin
              rx <= {rx[6:0], sp.serial_out_line};
            end else begin
              frame <= {frame[22:0], 1'b0};
              sdi_r <= frame[22];
              bits_left <= bits_left - 5'h01;
              if (bits_left == 5'h01) begin
                sel_n_r <= 1'b1;
                rsp_valid <= rd_r;
                rsp_rdata <= rx;
                guard_cnt <= soft_req ? 6'(`SOFT_RESET_CYC) : 6'h01;  // RL2
                state <= st_guard;
              end
            end
          end else begin
            half_cnt <= half_cnt + 2'h1;
          end
        end
        st_guard: begin
          if (guard_cnt == 6'h00) begin
            state <= st_idle;
          end else begin
            guard_cnt <= guard_cnt - 6'h01;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end
endmodule : spi_config_host

// ---- tb/align_ctrl_sva.sv ----
`timescale 1ns/100ps
// ==========================================
// serial wire checks
module align_ctrl_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial wires
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic serial_out_line
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence write_head;
    $fell(sel_n) ##2 ($rose(sclk) && !sdi);
  endsequence
  AST_IDLE_OUT: assert property (sel_n [*4] |-> !serial_out_line)
    else $error("output line active outside frame");
  AST_SCLK_IDLE: assert property (sel_n [*3] |-> !sclk)
    else $error("serial clock moves outside frame");
  AST_SCLK_HALF: assert property ($rose(sclk) && !sel_n |-> ##1 sclk ##1 !sclk)
    else $error("serial clock high phase not two cycles");
  AST_SDI_HOLD: assert property ($rose(sclk) && !sel_n |=> $stable(sdi))
    else $error("data in changed while clock high");
  AST_OUT_STAND: assert property (sclk && $past(sclk) |-> $stable(serial_out_line))
    else $error("output line changed in clock high phase");
  AST_FRAME_LEN: assert property ($fell(sel_n) |-> ##94 !sel_n ##[1:8] sel_n)
    else $error("frame length wrong");
  AST_FRAME_START: assert property ($fell(sel_n) |-> !sclk [*2])
    else $error("frame opens without low clock phase");
  AST_WRITE_QUIET: assert property (write_head |-> !serial_out_line [*8])
    else $error("output line driven during write");
  COV_READ: cover property ($fell(sel_n) ##2 ($rose(sclk) && sdi));
  COV_WRITE: cover property (write_head);
  COV_OUT_HIGH: cover property ($rose(serial_out_line));
endmodule : align_ctrl_sva

// ---- tb/spi_config_and_align_ctrl_tb.sv ----
`timescale 1ns/100ps
module spi_config_and_align_ctrl_tb;
  import align_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  reg_addr_t cmd_addr = '0;
  reg_byte_t cmd_wdata = '0;
  logic align_event = 1'b0;
  logic [23:0] align_edge_position = 24'habcdef;
  logic cmd_ready, rsp_valid, align_event_taken, power_down;
  logic recv_en, proc_en, fine_scale;
  logic [3:0] delay_choice;
  reg_byte_t rsp_rdata;
  reg_byte_t got;
  logic rst_busy;
  logic busy_seen = 1'b0;
  int bad_count = 0;
  int n_compared = 0;

  serial_port_if bus ();
  spi_config_host u_spi_config_host (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .sp(bus));
  spi_config_and_align_ctrl #(.MAKER_CODE(16'h1234)) u_spi_config_and_align_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sp(bus), .align_event(align_event),
    .align_edge_position(align_edge_position), .align_input_receiver_enable(recv_en),
    .align_event_process_enable(proc_en), .fine_window_scale(fine_scale),
    .align_delay_choice(delay_choice), .align_event_taken(align_event_taken),
    .power_down(power_down), .soft_reset_busy(rst_busy));
  align_ctrl_sva u_align_ctrl_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sclk(bus.sclk), .sel_n(bus.sel_n), .sdi(bus.sdi),
    .serial_out_line(bus.serial_out_line));

  initial forever #25 ref_clk = ~ref_clk;

  // remembers that the soft reset window was flagged
  always @(posedge ref_clk) begin
    if (rst_busy === 1'b1) begin
      busy_seen <= 1'b1;
    end
  end

  // ==========================================
  // access tasks
  task chk(input reg_byte_t seen, input reg_byte_t exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task xfer(input logic rd, input reg_addr_t a, input reg_byte_t d);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    got = 8'hxx;
    repeat (150) begin
      @(posedge ref_clk);
      if (rsp_valid === 1'b1) begin
        got = rsp_rdata;
        break;
      end
    end
    @(posedge ref_clk);
  endtask : xfer

  task rd(input reg_addr_t a, input reg_byte_t exp);
    xfer(1'b1, a, 8'h00);
    chk(got, exp);
  endtask : rd

  task ev(input logic exp);
    logic seen;
    seen = 1'b0;
    align_event <= 1'b1;
    @(posedge ref_clk);
    align_event <= 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      seen = seen | (align_event_taken === 1'b1);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask : ev

  task close_out;
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ==========================================
  // tests
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(15'h0000, 8'h30);
    rd(15'h0002, 8'h00);
    rd(15'h0010, 8'h00);
    rd(15'h0029, 8'h80);
    rd(15'h000d, 8'h12);
    xfer(1'b0, 15'h000c, 8'hff);
    rd(15'h000c, 8'h34);
    rd(15'h002d, 8'hcd);
    rd(15'h002e, 8'hab);
    xfer(1'b0, 15'h002c, 8'h00);
    rd(15'h002c, 8'hef);
    rd(15'h0007, 8'h00);
    xfer(1'b0, 15'h0000, 8'h00);
    rd(15'h0000, 8'h10);
    xfer(1'b0, 15'h0010, 8'h01);
    rd(15'h0010, 8'h01);
    ev(1'b0);
    xfer(1'b0, 15'h0029, 8'ha0);
    ev(1'b0);
    xfer(1'b0, 15'h0029, 8'he0);
    ev(1'b1);
    xfer(1'b0, 15'h0029, 8'hf5);
    chk({1'b0, proc_en, recv_en, fine_scale, delay_choice}, 8'h75);
    rd(15'h0029, 8'hf5);
    xfer(1'b0, 15'h0002, 8'h03);
    chk({7'h00, power_down}, 8'h01);
    chk({7'h00, busy_seen}, 8'h00);
    xfer(1'b0, 15'h0000, 8'hb0);
    repeat (16) @(posedge ref_clk);
    chk({7'h00, power_down}, 8'h00);
    chk({7'h00, busy_seen}, 8'h01);
    chk({7'h00, rst_busy}, 8'h00);
    rd(15'h0000, 8'h30);
    rd(15'h0029, 8'h80);
    rd(15'h0002, 8'h00);
    rd(15'h0010, 8'h00);
    close_out;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("unexpected at %0t: run stalled", $time);
    close_out;
  end
endmodule : spi_config_and_align_ctrl_tb
